/* fdor_consts.vh */
// Constants for the drive option and legacy input register bank.
`ifndef FDOR_CONSTS_VH
`define FDOR_CONSTS_VH
// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define FDOR_ADDR_INPUT 4'h0
`define FDOR_ADDR_OPTIONS 4'h4
`define FDOR_ADDR_IRQ_STAT 4'h8
`define FDOR_ADDR_IRQ_MASK 4'hC
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define FDOR_OPT_BOOT 0
`define FDOR_OPT_SOFT_TC 1
`define FDOR_OPT_PC_LO 2
`define FDOR_OPT_PC_HI 3
`define FDOR_OPT_NO_PC 4
`define FDOR_OPT_RESET 8'h08
`define FDOR_IN_RATE250 1
`define FDOR_IN_NOPC 2
`define FDOR_IN_DMAEN 3
`define FDOR_IN_DCHG 7
`define FDOR_RATE_300K 2'h1
`define FDOR_RESP_OKAY 2'h0
`define FDOR_RESP_SLVERR 2'h2
// Interrupt events: bit 0 disk change seen, bit 1 soft terminal count issued.
`define FDOR_IRQ_W 2
`endif

/* fdor_drive_swap.v */
// Boot-drive swap of select and motor lines, active low.
`timescale 1ns/1ns
module fdor_drive_swap (
   input wire bootSel,
   input wire [1:0] selInN,
   input wire [1:0] motorInN,
   output wire [1:0] selOutN,
   output wire [1:0] motorOutN
);
   // A zero boot bit boots from drive 1 by crossing lines 0 and 1.
   assign selOutN = bootSel ? selInN : {selInN[0], selInN[1]};
   assign motorOutN = bootSel ? motorInN : {motorInN[0], motorInN[1]};
endmodule // fdor_drive_swap

/* fdor_regs.v */
// Option register, legacy input register and AXI4-Lite slave.
`timescale 1ns/1ns
`include "fdor_consts.vh"
module fdor_regs (
   input wire core_clk,
   input wire rst_b,
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire legacyMode,
   input wire rate250,
   input wire dmaIrqEn,
   input wire diskChange,
   input wire cfgNoPrecomp,
   input wire [1:0] dataRate,
   input wire [1:0] drive_sel_in_n,
   input wire [1:0] motor_on_in_n,
   output reg [1:0] drive_sel_n_ff,
   output reg [1:0] motor_on_n_ff,
   output reg soft_terminal_count_ff,
   output reg [2:0] precomp_clocks_ff,
   output reg precomp_disable_ff,
   output reg precomp_clk2_ff,
   output reg irq_ff
);
   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   wire [5:0] pinSync;
   wire [1:0] selSyncN;
   wire [1:0] motSyncN;
   wire [1:0] selSwapN;
   wire [1:0] motSwapN;
   reg [7:0] optFf;
   reg [`FDOR_IRQ_W-1:0] irqStat_ff;
   reg [`FDOR_IRQ_W-1:0] irqMask_ff;
   reg dchgPrev_ff;
   reg [3:0] awAddr_ff;
   reg [31:0] wData_ff;
   reg wStrb0_ff;
   reg awHave_ff;
   reg wHave_ff;
   fdor_sync #(.W(10)) uSync (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .din({drive_sel_in_n, motor_on_in_n, rate250, dmaIrqEn, diskChange, cfgNoPrecomp,
         dataRate}),
      .dout_ff({selSyncN, motSyncN, pinSync})
   );
   wire rateS = pinSync[5];
   wire dmaS = pinSync[4];
   wire dchgS = pinSync[3];
   wire cfgNpS = pinSync[2];
   wire [1:0] rateSelS = pinSync[1:0];

   fdor_drive_swap uSwap (
      .bootSel(optFf[`FDOR_OPT_BOOT]),
      .selInN(selSyncN),
      .motorInN(motSyncN),
      .selOutN(selSwapN),
      .motorOutN(motSwapN)
   );

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------

   function [2:0] pcShift;
      input [1:0] code;
      begin
         pcShift = {1'b0, code} + 3'h1;
      end
   endfunction

   function isMapped;
      input [3:0] a;
      begin
         isMapped = (a == `FDOR_ADDR_INPUT) || (a == `FDOR_ADDR_OPTIONS) ||
            (a == `FDOR_ADDR_IRQ_STAT) || (a == `FDOR_ADDR_IRQ_MASK);
      end
   endfunction

   wire [7:0] inputView = {~dchgS, 3'h0, dmaS, legacyMode ? cfgNpS : optFf[`FDOR_OPT_NO_PC],
      rateS, 1'b0};
   wire doWrite = awHave_ff && wHave_ff && !s_axi_bvalid;
   wire doRead = s_axi_arvalid && s_axi_arready;
   wire readStat = doRead && (s_axi_araddr == `FDOR_ADDR_IRQ_STAT);
   wire wrOpt = doWrite && wStrb0_ff && (awAddr_ff == `FDOR_ADDR_OPTIONS);
   wire wrMask = doWrite && wStrb0_ff && (awAddr_ff == `FDOR_ADDR_IRQ_MASK);
   wire [`FDOR_IRQ_W-1:0] events = {wrOpt && wData_ff[`FDOR_OPT_SOFT_TC], dchgS && !dchgPrev_ff};
   wire [`FDOR_IRQ_W-1:0] nxt_irqStat = (readStat ? {`FDOR_IRQ_W{1'b0}} : irqStat_ff) | events;

   // ----------------------------------------------------------------
   // Write channel: address and data accepted in either order
   // ----------------------------------------------------------------
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         optFf <= `FDOR_OPT_RESET;
         irqMask_ff <= {`FDOR_IRQ_W{1'b0}};
         awAddr_ff <= 4'h0;
         wData_ff <= 32'h0;
         wStrb0_ff <= 1'b0;
         awHave_ff <= 1'b0;
         wHave_ff <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `FDOR_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            // Kept whole so an unaligned address is refused, not aliased.
            awAddr_ff <= s_axi_awaddr;
            awHave_ff <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wData_ff <= s_axi_wdata;
            wStrb0_ff <= s_axi_wstrb[0];
            wHave_ff <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wrOpt)
            optFf <= {3'h0, wData_ff[4:0]};
         if (wrMask)
            irqMask_ff <= wData_ff[`FDOR_IRQ_W-1:0];
         if (doWrite) begin
            awHave_ff <= 1'b0;
            wHave_ff <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= isMapped(awAddr_ff) ? `FDOR_RESP_OKAY : `FDOR_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `FDOR_RESP_OKAY;
      end else if (doRead) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= isMapped(s_axi_araddr) ? `FDOR_RESP_OKAY : `FDOR_RESP_SLVERR;
         case (s_axi_araddr)
            `FDOR_ADDR_INPUT: s_axi_rdata <= {24'h0, inputView};
            `FDOR_ADDR_OPTIONS: s_axi_rdata <= {24'h0, optFf};
            `FDOR_ADDR_IRQ_STAT: s_axi_rdata <= {30'h0, irqStat_ff};
            `FDOR_ADDR_IRQ_MASK: s_axi_rdata <= {30'h0, irqMask_ff};
            default: s_axi_rdata <= 32'h0;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Outputs to the drive, formatter core and precompensation datapath
   // ----------------------------------------------------------------
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         irqStat_ff <= {`FDOR_IRQ_W{1'b0}};
         dchgPrev_ff <= 1'b0;
         irq_ff <= 1'b0;
         drive_sel_n_ff <= 2'h3;
         motor_on_n_ff <= 2'h3;
         soft_terminal_count_ff <= 1'b0;
         precomp_clocks_ff <= 3'h1;
         precomp_disable_ff <= 1'b0;
         precomp_clk2_ff <= 1'b0;
      end else begin
         // An event in the clearing read's cycle survives it.
         irqStat_ff <= nxt_irqStat;
         dchgPrev_ff <= dchgS;
         irq_ff <= |(nxt_irqStat & irqMask_ff);
         drive_sel_n_ff <= selSwapN;
         motor_on_n_ff <= motSwapN;
         // A one-cycle pulse per write of the bit, so the core sees one count.
         soft_terminal_count_ff <= wrOpt && wData_ff[`FDOR_OPT_SOFT_TC];
         precomp_clocks_ff <= pcShift(optFf[`FDOR_OPT_PC_HI:`FDOR_OPT_PC_LO]);
         precomp_disable_ff <= legacyMode ? cfgNpS : optFf[`FDOR_OPT_NO_PC];
         precomp_clk2_ff <= (rateSelS == `FDOR_RATE_300K);
      end
   end
endmodule // fdor_regs

/* fdor_regs_sva.sv */
// Checker for the option and input register bank.
`timescale 1ns/1ns
module fdor_regs_sva (
   input wire core_clk,
   input wire rst_b,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [1:0] s_axi_bresp,
   input wire legacyMode,
   input wire cfgNoPrecomp,
   input wire [1:0] dataRate,
   input wire [1:0] drive_sel_in_n,
   input wire [1:0] drive_sel_n_ff,
   input wire soft_terminal_count_ff,
   input wire [2:0] precomp_clocks_ff,
   input wire precomp_disable_ff,
   input wire precomp_clk2_ff
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // Pin paths run through two sync flops, so only settled pins are judged.
   a_shift_clock_src: assert property ($stable(dataRate)[*4] |->
      precomp_clk2_ff == (dataRate == 2'h1)) else $error("shift clock source wrong");
   a_legacy_nwp_src: assert property ((legacyMode && $stable(cfgNoPrecomp))[*5] |->
      precomp_disable_ff == cfgNoPrecomp) else $error("legacy precomp disable wrong");
   a_idle_select: assert property ((drive_sel_in_n == 2'h3)[*5] |->
      drive_sel_n_ff == 2'h3) else $error("idle select not idle");
   a_tc_pulse: assert property (soft_terminal_count_ff |=> !soft_terminal_count_ff)
      else $error("terminal count not a pulse");
   a_precomp_range: assert property (precomp_clocks_ff inside {[3'h1:3'h4]})
      else $error("precomp shift out of range");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
   a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response not held");
endmodule // fdor_regs_sva

/* fdor_sync.v */
// Two-flop synchroniser for a vector of pin levels.
`timescale 1ns/1ns
module fdor_sync #(
   parameter W = 1
) (
   input wire core_clk,
   input wire rst_b,
   input wire [W-1:0] din,
   output reg [W-1:0] dout_ff
);
   reg [W-1:0] meta_ff;
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_ff <= {W{1'b0}};
         dout_ff <= {W{1'b0}};
      end else begin
         meta_ff <= din;
         dout_ff <= meta_ff;
      end
   end
endmodule // fdor_sync

/* tb_fdc_option_and_input_regs.sv */
// Testbench for the option and input register bank.
`timescale 1ns/1ns
module tb_fdc_option_and_input_regs;
   reg core_clk = 1'b0;
   reg rst_b = 1'b0;
   reg [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
   reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   reg s_axi_rready = 0, legacyMode = 0, rate250 = 0, dmaIrqEn = 0;
   reg diskChange = 0, cfgNoPrecomp = 0;
   reg [31:0] s_axi_wdata = 32'h0;
   reg [1:0] dataRate = 2'h0, drive_sel_in_n = 2'h3, motor_on_in_n = 2'h3;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp, drive_sel_n_ff, motor_on_n_ff;
   wire [31:0] s_axi_rdata;
   wire soft_terminal_count_ff, precomp_disable_ff, precomp_clk2_ff, irq_ff;
   wire [2:0] precomp_clocks_ff;
   integer num_errors = 0, n_compared = 0, cyc = 0, tcCnt = 0, k;
   reg [31:0] rd;
   reg [1:0] expResp = 2'h0;
   fdor_regs u_dut (.*);
   initial forever #5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (soft_terminal_count_ff === 1'b1) tcCnt <= tcCnt + 1;
      if (cyc == 4000) begin
         num_errors = num_errors + 1;
         end_sim;
      end
   end
   // ------------------------------------------------------------
   // Bus cycles and checks
   // ------------------------------------------------------------
   task chk(input string nm, input [31:0] e, input [31:0] g);
      begin
         n_compared = n_compared + 1;
         if (g !== e) begin
            num_errors = num_errors + 1;
            $display("Error %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task wr(input [3:0] a, input [7:0] d);
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= {24'h0, d};
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         #1;
         while (s_axi_awvalid || s_axi_wvalid) begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            #1;
         end
         while (s_axi_bvalid !== 1'b1) begin @(posedge core_clk); #1; end
         s_axi_bready <= 1'b1;
         @(posedge core_clk);
         chk("bresp", expResp, s_axi_bresp);
         s_axi_bready <= 1'b0;
      end
   endtask
   task rdr(input [3:0] a, output [31:0] d);
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         @(posedge core_clk);
         while (s_axi_arready !== 1'b1) @(posedge core_clk);
         s_axi_arvalid <= 1'b0;
         #1;
         while (s_axi_rvalid !== 1'b1) begin @(posedge core_clk); #1; end
         s_axi_rready <= 1'b1;
         @(posedge core_clk);
         d = s_axi_rdata;
         chk("rresp", expResp, s_axi_rresp);
         s_axi_rready <= 1'b0;
      end
   endtask
   task end_sim;
      begin
         $display("Compared %0d mismatches %0d", n_compared, num_errors);
         if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
         else $display("TESTS FAILED");
         $finish;
      end
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_reset;
      begin
         repeat (4) @(posedge core_clk);
         rdr(4'h4, rd);
         chk("options", 32'h08, rd);
         chk("clocks", 32'h3, precomp_clocks_ff);
         rdr(4'h0, rd);
         chk("input", 32'h80, rd);
         $display("reset test done");
      end
   endtask
   task t_input;
      begin
         {legacyMode, rate250, dmaIrqEn, cfgNoPrecomp, diskChange} <= 5'h1F;
         repeat (5) @(posedge core_clk);
         rdr(4'h0, rd);
         chk("input", 32'h0E, rd);
         chk("nwp", 32'h1, precomp_disable_ff);
         cfgNoPrecomp <= 1'b0;
         wr(4'h4, 8'h10);
         repeat (4) @(posedge core_clk);
         chk("nwp", 32'h0, precomp_disable_ff);
         legacyMode <= 1'b0;
         repeat (3) @(posedge core_clk);
         chk("nwp", 32'h1, precomp_disable_ff);
         $display("input test done");
      end
   endtask
   task t_swap;
      begin
         drive_sel_in_n <= 2'h2;
         motor_on_in_n <= 2'h2;
         repeat (5) @(posedge core_clk);
         chk("sel", 32'h5, {motor_on_n_ff, drive_sel_n_ff});
         wr(4'h4, 8'h01);
         repeat (2) @(posedge core_clk);
         chk("sel", 32'hA, {motor_on_n_ff, drive_sel_n_ff});
         drive_sel_in_n <= 2'h3;
         motor_on_in_n <= 2'h3;
         $display("swap test done");
      end
   endtask
   task t_precomp;
      begin
         for (k = 0; k < 4; k = k + 1) begin
            wr(4'h4, k[1:0] << 2);
            repeat (2) @(posedge core_clk);
            chk("clocks", k + 1, precomp_clocks_ff);
         end
         dataRate <= 2'h1;
         repeat (5) @(posedge core_clk);
         chk("clk2", 32'h1, precomp_clk2_ff);
         dataRate <= 2'h2;
         repeat (5) @(posedge core_clk);
         chk("clk2", 32'h0, precomp_clk2_ff);
         $display("precomp test done");
      end
   endtask
   task t_irq;
      begin
         chk("tc", 32'h0, tcCnt);
         rdr(4'h8, rd);
         chk("status", 32'h1, rd);
         wr(4'hC, 8'h02);
         wr(4'h4, 8'h02);
         repeat (2) @(posedge core_clk);
         chk("tc", 32'h1, tcCnt);
         chk("irq", 32'h1, irq_ff);
         rdr(4'h8, rd);
         chk("status", 32'h2, rd);
         repeat (2) @(posedge core_clk);
         chk("irq", 32'h0, irq_ff);
         wr(4'hC, 8'h00);
         wr(4'h4, 8'h02);
         repeat (2) @(posedge core_clk);
         chk("irq", 32'h0, irq_ff);
         $display("irq test done");
      end
   endtask
   task t_refuse;
      begin
         expResp = 2'h2;
         wr(4'h5, 8'h1F);
         rdr(4'h1, rd);
         chk("unmapped", 32'h0, rd);
         expResp = 2'h0;
         s_axi_wstrb <= 4'h0;
         wr(4'h4, 8'h10);
         s_axi_wstrb <= 4'hF;
         rdr(4'h4, rd);
         chk("options", 32'h02, rd);
         $display("refuse test done");
      end
   endtask
   initial begin
      repeat (8) @(posedge core_clk);
      rst_b <= 1'b1;
      t_reset;
      t_input;
      t_swap;
      t_precomp;
      t_irq;
      t_refuse;
      end_sim;
   end
endmodule // tb_fdc_option_and_input_regs
bind fdor_regs fdor_regs_sva u_sva (.*);
